// file: rtl/arc_consts.svh
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// ==========================================================================
// Register offsets
`define ARC_OFS_GEN_CFG      8'h03
`define ARC_OFS_DESER_ADDR   8'h06
`define ARC_OFS_DESER_ALIAS  8'h07
`define ARC_OFS_SLAVE_ADDR   8'h08
`define ARC_OFS_SLAVE_ALIAS  8'h09

// ==========================================================================
// Field positions
`define ARC_BIT_EDGE_SEL     0
`define ARC_BIT_PASS_THRU    2
`define ARC_BIT_PASS_ALL     3
`define ARC_BIT_HOLD         0
`define ARC_ADDR_MSB         7
`define ARC_ADDR_LSB         1

// ==========================================================================
// Reset values
`define ARC_RST_GEN_CFG      8'hC5
`define ARC_RST_DESER_ADDR   7'h00
`define ARC_RST_HOLD         1'b0
`define ARC_RST_DESER_ALIAS  7'h00
`define ARC_RST_SLAVE_ADDR   7'h00
`define ARC_RST_SLAVE_ALIAS  7'h00
`define ARC_ADDR_NONE        7'h00

`endif

// file: rtl/arc_pkg.sv
package arc_pkg;

  // ========================================================================
  // Forwarding target
  typedef enum logic [1:0] {
    ARC_TGT_NONE  = 2'b00,
    ARC_TGT_DESER = 2'b01,
    ARC_TGT_SLAVE = 2'b10,
    ARC_TGT_PASS  = 2'b11
  } arc_target_e;

  // ========================================================================
  // Address byte request from the local I2C host side
  typedef struct packed {
    logic       valid;
    logic [7:0] addr_byte;
  } arc_req_s;

  // Translated address byte toward the control channel
  typedef struct packed {
    logic        valid;
    logic        drop;
    arc_target_e target;
    logic [7:0]  addr_byte;
  } arc_fwd_s;

  // Address learned over the back channel
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } arc_learn_s;

  // Register write strobe
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arc_reg_s;

  // ========================================================================
  // Module state clocked on the rising edge
  typedef struct packed {
    logic [7:0] gen_cfg;
    logic [6:0] deser_addr;
    logic       hold;
    logic [6:0] deser_alias;
    logic [6:0] slave_addr;
    logic [6:0] slave_alias;
    logic [1:0] lock_sync;
    logic [7:0] rdata;
    arc_fwd_s   fwd;
    logic [7:0] audio_rise;
    logic [7:0] audio_out;
  } arc_state_s;

endpackage

// file: rtl/arc_top.sv
// Function
// - Edge-select 1 samples audio on rising edge, 0 on falling edge.
// - Hold 7-bit deserializer address; deserializer alias hits forward that address.
// - After receive lock, load deserializer address learned over back channel.
// - Hold bit 1 blocks automatic load and keeps the written address.
// - Hold bit 0 allows automatic load from the back channel.
// - Zero address or alias disables access to that remote target.
// - Transactions to deserializer alias are redirected to deserializer address.
// - Hold 7-bit remote slave address; slave alias hits forward that address.
// - Transactions to slave alias are redirected to remote slave address.
// - With pass-all off, only alias matches cross the link.
`include "arc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module arc_top
  import arc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire arc_reg_s   REG_IN,
  output var  logic [7:0] REG_RDATA,
  input  wire logic       RX_LOCK,
  input  wire arc_learn_s LEARN_IN,
  input  wire arc_req_s   REQ_IN,
  output var  arc_fwd_s   FWD_OUT,
  input  wire logic [7:0] AUDIO_IN,
  output var  logic [7:0] AUDIO_OUT
);

  // ========================================================================
  // State
  arc_state_s s_q;
  arc_state_s s_d;
  logic [7:0] audio_fall_q;

  logic [6:0] req_addr;
  logic       req_rw;
  logic       lock_s;
  logic       deser_hit;
  logic       slave_hit;
  logic       pass_hit;
  logic       pass_thru;
  logic       pass_all;

  assign req_addr  = REQ_IN.addr_byte[`ARC_ADDR_MSB:`ARC_ADDR_LSB];
  assign req_rw    = REQ_IN.addr_byte[0];
  assign lock_s    = s_q.lock_sync[1];
  assign pass_thru = s_q.gen_cfg[`ARC_BIT_PASS_THRU];
  assign pass_all  = s_q.gen_cfg[`ARC_BIT_PASS_ALL];

  // ========================================================================
  // Alias matching, zero fields disable the target
  assign deser_hit = (s_q.deser_alias != `ARC_ADDR_NONE)
                   & (s_q.deser_addr != `ARC_ADDR_NONE)
                   & (req_addr == s_q.deser_alias);
  assign slave_hit = (s_q.slave_alias != `ARC_ADDR_NONE)
                   & (s_q.slave_addr != `ARC_ADDR_NONE)
                   & (req_addr == s_q.slave_alias)
                   & ~deser_hit;
  assign pass_hit  = pass_all
                   & (s_q.deser_addr != `ARC_ADDR_NONE)
                   & ~deser_hit & ~slave_hit;

  // ========================================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Lock crosses in from the link side
    s_d.lock_sync = {s_q.lock_sync[0], RX_LOCK};

    // Automatic load, software write below takes precedence
    if (lock_s && LEARN_IN.valid && !s_q.hold) begin
      s_d.deser_addr = LEARN_IN.addr;
    end

    // Register writes
    if (REG_IN.wr) begin
      case (REG_IN.addr)
        `ARC_OFS_GEN_CFG: begin
          s_d.gen_cfg = REG_IN.wdata;
        end
        `ARC_OFS_DESER_ADDR: begin
          s_d.deser_addr = REG_IN.wdata[`ARC_ADDR_MSB:`ARC_ADDR_LSB];
          s_d.hold       = REG_IN.wdata[`ARC_BIT_HOLD];
        end
        `ARC_OFS_DESER_ALIAS: begin
          s_d.deser_alias = REG_IN.wdata[`ARC_ADDR_MSB:`ARC_ADDR_LSB];
        end
        `ARC_OFS_SLAVE_ADDR: begin
          s_d.slave_addr = REG_IN.wdata[`ARC_ADDR_MSB:`ARC_ADDR_LSB];
        end
        `ARC_OFS_SLAVE_ALIAS: begin
          s_d.slave_alias = REG_IN.wdata[`ARC_ADDR_MSB:`ARC_ADDR_LSB];
        end
        default: begin
        end
      endcase
    end

    // Registered read data, unmapped offsets read zero
    case (REG_IN.addr)
      `ARC_OFS_GEN_CFG:     s_d.rdata = s_q.gen_cfg;
      `ARC_OFS_DESER_ADDR:  s_d.rdata = {s_q.deser_addr, s_q.hold};
      `ARC_OFS_DESER_ALIAS: s_d.rdata = {s_q.deser_alias, 1'b0};
      `ARC_OFS_SLAVE_ADDR:  s_d.rdata = {s_q.slave_addr, 1'b0};
      `ARC_OFS_SLAVE_ALIAS: s_d.rdata = {s_q.slave_alias, 1'b0};
      default:              s_d.rdata = 8'h00;
    endcase

    // Address translation
    s_d.fwd.valid     = REQ_IN.valid;
    s_d.fwd.drop      = 1'b0;
    s_d.fwd.target    = ARC_TGT_NONE;
    s_d.fwd.addr_byte = REQ_IN.addr_byte;
    if (REQ_IN.valid) begin
      if (!pass_thru) begin
        s_d.fwd.drop = 1'b1;
      end else if (deser_hit) begin
        s_d.fwd.target    = ARC_TGT_DESER;
        s_d.fwd.addr_byte = {s_q.deser_addr, req_rw};
      end else if (slave_hit) begin
        s_d.fwd.target    = ARC_TGT_SLAVE;
        s_d.fwd.addr_byte = {s_q.slave_addr, req_rw};
      end else if (pass_hit) begin
        s_d.fwd.target    = ARC_TGT_PASS;
        s_d.fwd.addr_byte = {s_q.deser_addr, req_rw};
      end else begin
        s_d.fwd.drop = 1'b1;
      end
    end

    // Audio capture edge select
    s_d.audio_rise = AUDIO_IN;
    s_d.audio_out  = s_q.gen_cfg[`ARC_BIT_EDGE_SEL] ? s_q.audio_rise
                                                     : audio_fall_q;
  end

  // ========================================================================
  // Falling-edge audio capture
  always_ff @(negedge CLK or negedge NRST) begin
    if (!NRST) begin
      audio_fall_q <= 8'h00;
    end else begin
      audio_fall_q <= AUDIO_IN;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_q             <= '0;
      s_q.gen_cfg     <= `ARC_RST_GEN_CFG;
      s_q.deser_addr  <= `ARC_RST_DESER_ADDR;
      s_q.hold        <= `ARC_RST_HOLD;
      s_q.deser_alias <= `ARC_RST_DESER_ALIAS;
      s_q.slave_addr  <= `ARC_RST_SLAVE_ADDR;
      s_q.slave_alias <= `ARC_RST_SLAVE_ALIAS;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA = s_q.rdata;
  assign FWD_OUT   = s_q.fwd;
  assign AUDIO_OUT = s_q.audio_out;

endmodule // arc_top

`default_nettype wire

// file: verification/arc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module arc_assertions
  import arc_pkg::*;
(
  input wire logic       CLK,
  input wire logic       NRST,
  input wire arc_reg_s   REG_IN,
  input wire logic [7:0] REG_RDATA,
  input wire arc_req_s   REQ_IN,
  input wire arc_fwd_s   FWD_OUT,
  input wire logic [7:0] AUDIO_IN,
  input wire logic [7:0] AUDIO_OUT
);
  logic [7:0] cfg_q;
  logic [6:0] da_q, sa_q, sd_q;
  logic [1:0] run_q;
  logic       hold_q;
  wire  [6:0] a = REQ_IN.addr_byte[7:1];
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ==========
  // Shadow of written fields
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= 8'hC5;
      {da_q, sa_q, sd_q, hold_q, run_q} <= '0;
    end else begin
      run_q <= (run_q == 2'h3) ? run_q : run_q + 2'h1;
      if (REG_IN.wr) begin
        case (REG_IN.addr)
          8'h03: cfg_q <= REG_IN.wdata;
          8'h06: hold_q <= REG_IN.wdata[0];
          8'h07: da_q <= REG_IN.wdata[7:1];
          8'h08: sd_q <= REG_IN.wdata[7:1];
          8'h09: sa_q <= REG_IN.wdata[7:1];
          default: ;
        endcase
      end
    end
  end
  // ==========
  // Properties
  a_fwd_one_later: assert property (REQ_IN.valid |=> FWD_OUT.valid)
    else $error("forward missing");
  a_no_spur_fwd: assert property (!REQ_IN.valid |=> !FWD_OUT.valid)
    else $error("spurious forward");
  a_rw_bit_kept: assert property (REQ_IN.valid |=> FWD_OUT.drop ||
    FWD_OUT.addr_byte[0] == $past(REQ_IN.addr_byte[0])) else $error("rw bit changed");
  a_alias_readback: assert property ((REG_IN.wr && REG_IN.addr == 8'h09) ##1
    (!REG_IN.wr && REG_IN.addr == 8'h09) |=>
    REG_RDATA == {$past(REG_IN.wdata[7:1], 2), 1'b0}) else $error("alias readback");
  a_hold_freeze: assert property ((hold_q && !REG_IN.wr && REG_IN.addr == 8'h06) [*2]
    |=> $stable(REG_RDATA)) else $error("frozen address changed");
  a_audio_rise: assert property (run_q == 2'h3 && cfg_q[0] && $past(cfg_q[0]) &&
    $past(cfg_q[0], 2) |-> AUDIO_OUT == $past(AUDIO_IN, 2)) else $error("audio sample");
  a_slave_remap: assert property (REQ_IN.valid && cfg_q[2] && a == sa_q && a != da_q &&
    sa_q != 0 && sd_q != 0 |=> !FWD_OUT.drop && FWD_OUT.target == ARC_TGT_SLAVE &&
    FWD_OUT.addr_byte[7:1] == $past(sd_q)) else $error("slave remap");
  a_nomatch_drop: assert property (REQ_IN.valid && !cfg_q[3] && (a != da_q || da_q == 0) &&
    (a != sa_q || sa_q == 0 || sd_q == 0) |=> FWD_OUT.drop) else $error("unmatched passed");
  a_passthru_off: assert property (REQ_IN.valid && !cfg_q[2] |=> FWD_OUT.drop)
    else $error("forward while disabled");
  c_deser: cover property (FWD_OUT.valid && FWD_OUT.target == ARC_TGT_DESER);
  c_slave: cover property (FWD_OUT.valid && FWD_OUT.target == ARC_TGT_SLAVE);
  c_pass: cover property (FWD_OUT.valid && FWD_OUT.target == ARC_TGT_PASS);
endmodule // arc_assertions
bind arc_top arc_assertions arc_assertions_i (.CLK(CLK), .NRST(NRST), .REG_IN(REG_IN),
  .REG_RDATA(REG_RDATA), .REQ_IN(REQ_IN), .FWD_OUT(FWD_OUT), .AUDIO_IN(AUDIO_IN),
  .AUDIO_OUT(AUDIO_OUT));
`default_nettype wire

// file: verification/arc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module arc_partner
  import arc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       up,
  input  wire logic [6:0] id,
  output var  logic       lock,
  output var  arc_learn_s learn
);
  logic [3:0] cnt_q = 4'h0;
  initial begin
    lock = 1'b0;
    learn = '0;
  end
  // ==========
  // Lock, then address announced every 16 cycles
  always @(negedge clk) begin
    lock <= up;
    cnt_q <= up ? cnt_q + 4'h1 : 4'h0;
    learn <= (up && cnt_q == 4'h5) ? {1'b1, id} : {1'b0, ~id};
  end
endmodule // arc_partner
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import arc_pkg::*;
  logic        clk, nrst, up, lock, aud_free;
  logic [6:0]  id, da, sa, sd, dd;
  logic [7:0]  cfg, ain, aout, rdata, aud_v;
  logic [15:0] rv [6] = '{16'h03C5, 16'h0600, 16'h0700, 16'h0800, 16'h0900, 16'h0A00};
  arc_reg_s    reg_in;
  arc_req_s    req;
  arc_fwd_s    fwd;
  arc_learn_s  learn;
  int          n_mismatch, comparisons, seed, m, r;
  arc_top arc_top_i (.CLK(clk), .NRST(nrst), .REG_IN(reg_in), .REG_RDATA(rdata), .RX_LOCK(lock),
    .LEARN_IN(learn), .REQ_IN(req), .FWD_OUT(fwd), .AUDIO_IN(ain), .AUDIO_OUT(aout));
  arc_partner arc_partner_i (.clk(clk), .up(up), .id(id), .lock(lock), .learn(learn));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) ain <= aud_free ? ain * 8'd5 + 8'd3 : aud_v;
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [10:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) reg_in <= '{1'b1, a, d};
    @(negedge clk) reg_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk) reg_in.addr <= a;
    @(negedge clk);
    for (int k = 0; k < 40 && rdata !== e; k++) @(negedge clk);
    chk("rdata", {3'b0, e}, {3'b0, rdata});
  endtask
  function automatic logic [10:0] exp_fwd(input logic [7:0] b);
    if (cfg[2] && da != 0 && dd != 0 && b[7:1] == da) return {1'b0, ARC_TGT_DESER, dd, b[0]};
    if (cfg[2] && sa != 0 && sd != 0 && b[7:1] == sa) return {1'b0, ARC_TGT_SLAVE, sd, b[0]};
    if (cfg[2] && cfg[3] && dd != 0) return {1'b0, ARC_TGT_PASS, dd, b[0]};
    return 11'h400;
  endfunction
  task automatic req_chk(input logic [7:0] b);
    logic [10:0] e;
    e = exp_fwd(b);
    @(negedge clk) req <= '{1'b1, b};
    @(negedge clk) req.valid <= 1'b0;
    chk("fwd", e, e[10] ? {fwd.drop, 10'h0} : {fwd.drop, fwd.target, fwd.addr_byte});
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    seed = 32'h13cc_612b;
    {nrst, up, aud_free, aud_v, reg_in, req} = '0;
    {id, cfg, dd, da, sa, sd} = {7'h3A, 8'hC5, 7'h00, 7'h21, 7'h33, 7'h50};
    repeat (5) @(negedge clk);
    nrst <= 1'b1;
    wr(8'h0A, 8'hFF);
    foreach (rv[k]) rd(rv[k][15:8], rv[k][7:0]);
    wr(8'h07, {da, 1'b1});
    wr(8'h09, {sa, 1'b1});
    wr(8'h08, {sd, 1'b1});
    rd(8'h07, {da, 1'b0});
    rd(8'h08, {sd, 1'b0});
    req_chk({da, 1'b1});
    up <= 1'b1;
    dd = id;
    rd(8'h06, {dd, 1'b0});
    req_chk({da, 1'b0});
    dd = 7'h15;
    wr(8'h06, {dd, 1'b1});
    id <= 7'h4C;
    repeat (40) @(negedge clk);
    rd(8'h06, {dd, 1'b1});
    wr(8'h06, {dd, 1'b0});
    dd = id;
    rd(8'h06, {dd, 1'b0});
    for (m = 0; m < 4; m++) begin
      cfg = {4'hC, m[1:0], 2'b01};
      wr(8'h03, cfg);
      repeat (16) begin
        r = $random(seed);
        req_chk(r[1:0] == 0 ? {da, r[8]} : r[1:0] == 1 ? {sa, r[8]} : r[15:8]);
      end
    end
    cfg = 8'hC5;
    wr(8'h03, cfg);
    wr(8'h09, 8'h00);
    sa = 7'h00;
    req_chk({7'h33, 1'b1});
    req_chk(8'h01);
    for (m = 0; m < 2; m++) begin
      wr(8'h03, {7'h62, m[0]});
      aud_free = 1'b0;
      aud_v = $random(seed);
      repeat (4) @(negedge clk);
      chk("audio", {3'b0, aud_v}, {3'b0, aout});
      aud_free = 1'b1;
    end
    results();
  end
endmodule // testbench
`default_nettype wire
